// >>> hw/vgaac_defines.svh
`ifndef VGAAC_DEFINES_SVH
`define VGAAC_DEFINES_SVH

// ----------------------------------------
// i/o addresses
// ----------------------------------------
`define VGAAC_IO_ATTR_WR   10'h3C0
`define VGAAC_IO_ATTR_RD   10'h3C1
`define VGAAC_IO_MASK      10'h3C6
`define VGAAC_IO_RD_INDEX  10'h3C7
`define VGAAC_IO_WR_INDEX  10'h3C8
`define VGAAC_IO_DATA      10'h3C9

// ----------------------------------------
// attribute indices
// ----------------------------------------
`define VGAAC_IDX_PAL_LAST 5'h0F
`define VGAAC_IDX_MODE     5'h10
`define VGAAC_IDX_BORDER   5'h11
`define VGAAC_IDX_PLANE    5'h12
`define VGAAC_IDX_PAN      5'h13
`define VGAAC_IDX_CSEL     5'h14

// ----------------------------------------
// field positions and write masks
// ----------------------------------------
`define VGAAC_MODE_PSEL    7
`define VGAAC_MODE_WIDE    6
`define VGAAC_MODE_PAN     5
`define VGAAC_MODE_BLINK   3
`define VGAAC_MODE_NINTH   2
`define VGAAC_MODE_MONO    1
`define VGAAC_MODE_GFX     0
`define VGAAC_INDEX_PAS    5
`define VGAAC_MODE_WMASK   8'hEF
`define VGAAC_LOW4_WMASK   8'h0F
`define VGAAC_INDEX_WMASK  8'h3F

// ----------------------------------------
// reset values and panning codes
// ----------------------------------------
`define VGAAC_RST_REG      8'h00
`define VGAAC_RST_MASK     8'hFF
`define VGAAC_PAN_MAX      4'h7
`define VGAAC_PAN_256_MAX  4'h6

`endif

// >>> hw/vgaac_pkg.sv
package vgaac_pkg;

  // ----------------------------------------
  // host i/o request
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } vgaac_io_s;

  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [1:0] {
    VGAAC_AF_INDEX = 2'b01,
    VGAAC_AF_DATA  = 2'b10
  } vgaac_af_e;

  typedef enum logic [2:0] {
    VGAAC_COMP_RED   = 3'b001,
    VGAAC_COMP_GREEN = 3'b010,
    VGAAC_COMP_BLUE  = 3'b100
  } vgaac_comp_e;

endpackage : vgaac_pkg

// >>> hw/vgaac_palette_port.sv
`timescale 1ns/1ps
`include "vgaac_defines.svh"

module vgaac_palette_port (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire vgaac_pkg::vgaac_io_s io,
  output logic       [7:0]       host_data,
  output logic       [7:0]       wr_index,
  output logic       [7:0]       state_view,
  input  wire logic              vid_valid,
  input  wire logic  [7:0]       vid_index,
  output logic       [23:0]      rgb,
  output logic                   rgb_valid
);

  logic [23:0]              ram_color [256];
  logic [7:0]               rd_index;
  logic [7:0]               stage_r;
  logic [7:0]               stage_g;
  logic                     dir_read;
  vgaac_pkg::vgaac_comp_e   comp;
  vgaac_pkg::vgaac_comp_e   next_comp;
  logic [1:0]               comp_code;
  logic                     data_cyc;
  logic [23:0]              rd_entry;

  assign data_cyc = (io.wr || io.rd) && io.addr == `VGAAC_IO_DATA;
  assign rd_entry = ram_color[rd_index];

  // ----------------------------------------
  // component sequencer
  // ----------------------------------------
  always_comb
  begin
    case (comp)
      vgaac_pkg::VGAAC_COMP_RED:
      begin
        next_comp = vgaac_pkg::VGAAC_COMP_GREEN;
        comp_code = 2'h0;
        host_data = rd_entry[23:16];
      end
      vgaac_pkg::VGAAC_COMP_GREEN:
      begin
        next_comp = vgaac_pkg::VGAAC_COMP_BLUE;
        comp_code = 2'h1;
        host_data = rd_entry[15:8];
      end
      vgaac_pkg::VGAAC_COMP_BLUE:
      begin
        next_comp = vgaac_pkg::VGAAC_COMP_RED;
        comp_code = 2'h2;
        host_data = rd_entry[7:0];
      end
      default:
      begin
        next_comp = vgaac_pkg::VGAAC_COMP_RED;
        comp_code = 2'h3;
        host_data = 8'h00;
      end
    endcase
  end

  // sense status has no analog comparator here, so bit 3 reads zero
  assign state_view = {5'h00, dir_read, comp_code};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_index <= 8'h00;
      rd_index <= 8'h00;
      comp     <= vgaac_pkg::VGAAC_COMP_RED;
      dir_read <= 1'b0;
    end
    else if (ce)
    begin
      if (io.wr && io.addr == `VGAAC_IO_WR_INDEX)
      begin
        wr_index <= io.wdata;
        comp     <= vgaac_pkg::VGAAC_COMP_RED;
        dir_read <= 1'b0;
      end
      else if (io.wr && io.addr == `VGAAC_IO_RD_INDEX)
      begin
        rd_index <= io.wdata;
        comp     <= vgaac_pkg::VGAAC_COMP_RED;
        dir_read <= 1'b1;
      end
      else if (data_cyc)
      begin
        comp <= next_comp;
        if (comp == vgaac_pkg::VGAAC_COMP_BLUE && io.wr)
          wr_index <= wr_index + 8'h01;
        if (comp == vgaac_pkg::VGAAC_COMP_BLUE && io.rd)
          rd_index <= rd_index + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // colour storage, written whole after blue
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage_r <= 8'h00;
      stage_g <= 8'h00;
    end
    else if (ce && io.wr && data_cyc)
    begin
      if (comp == vgaac_pkg::VGAAC_COMP_RED)
        stage_r <= io.wdata;
      if (comp == vgaac_pkg::VGAAC_COMP_GREEN)
        stage_g <= io.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && io.wr && data_cyc && comp == vgaac_pkg::VGAAC_COMP_BLUE)
      ram_color[wr_index] <= {stage_r, stage_g, io.wdata};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rgb       <= 24'h000000;
      rgb_valid <= 1'b0;
    end
    else if (ce)
    begin
      rgb_valid <= vid_valid;
      if (vid_valid)
        rgb <= ram_color[vid_index];
    end
  end

  a_comp_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && io.wr && (io.addr == `VGAAC_IO_WR_INDEX || io.addr == `VGAAC_IO_RD_INDEX))
    |=> (comp == vgaac_pkg::VGAAC_COMP_RED && state_view[1:0] == 2'h0))
    else $error("component sequence not restarted by index write");

  a_wr_index_step: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && io.wr && data_cyc && comp == vgaac_pkg::VGAAC_COMP_BLUE)
    |=> wr_index == $past(wr_index) + 8'h01)
    else $error("write index did not advance after blue");

  a_dir_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && io.wr && io.addr == `VGAAC_IO_RD_INDEX) |=> state_view[2])
    else $error("direction flag not set to read");

endmodule : vgaac_palette_port

// >>> hw/vgaac_regs.sv
`timescale 1ns/1ps
`include "vgaac_defines.svh"

module vgaac_regs (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CORE_CE,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [9:0]  IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_RVALID,
  input  wire logic        DOT_EN,
  input  wire logic [3:0]  PIX_PLANES,
  input  wire logic [7:0]  PIX_DATA256,
  input  wire logic        PIX_BORDER,
  input  wire logic        PIX_NINTH,
  input  wire logic        LINE_COMPARE,
  output logic      [3:0]  PAN_SHIFT,
  output logic             DOUBLE_WIDE,
  output logic             BLINK_ENABLE,
  output logic             NINTH_DOT_COPY,
  output logic             MONO_EMULATION,
  output logic             GRAPHICS_MODE,
  output logic             PAL_ADDR_FROM_DISPLAY,
  output logic      [7:0]  PIX_INDEX,
  output logic             PIX_INDEX_VALID,
  output logic      [23:0] PIX_RGB,
  output logic             PIX_RGB_VALID
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  vgaac_pkg::vgaac_io_s   io_req;
  vgaac_pkg::vgaac_af_e   af_state;
  logic [7:0]             attribute_index_data;
  logic [7:0]             attribute_mode;
  logic [7:0]             border_color;
  logic [7:0]             plane_enable;
  logic [7:0]             smooth_pan;
  logic [7:0]             palette_high_bits;
  logic [7:0]             vga_pixel_mask;
  logic [5:0]             attribute_palette_entry [16];
  logic                   attr_data_wr;
  logic [7:0]             attr_rdata;
  logic [7:0]             next_rdata;
  logic [7:0]             dac_data;
  logic [7:0]             dac_wr_index;
  logic [7:0]             dac_state_view;
  logic [3:0]             pan_code;
  logic [3:0]             next_pan;
  logic                   dot_phase;
  logic                   pix_load;
  logic [3:0]             attr_idx;
  logic [5:0]             entry;
  logic [7:0]             next_color;
  logic [7:0]             held_color;

  assign io_req       = {IO_WR, IO_RD, IO_ADDR, IO_WDATA};
  assign attr_data_wr = IO_WR && IO_ADDR == `VGAAC_IO_ATTR_WR
                        && af_state == vgaac_pkg::VGAAC_AF_DATA;

  // ----------------------------------------
  // attribute index/data flip-flop
  // ----------------------------------------
  // only reset and the data write return to index; no external reset hook
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      af_state             <= vgaac_pkg::VGAAC_AF_INDEX;
      attribute_index_data <= `VGAAC_RST_REG;
    end
    else if (CORE_CE && IO_WR && IO_ADDR == `VGAAC_IO_ATTR_WR)
    begin
      case (af_state)
        vgaac_pkg::VGAAC_AF_INDEX:
        begin
          attribute_index_data <= IO_WDATA & `VGAAC_INDEX_WMASK;
          af_state             <= vgaac_pkg::VGAAC_AF_DATA;
        end
        vgaac_pkg::VGAAC_AF_DATA:
          af_state <= vgaac_pkg::VGAAC_AF_INDEX;
        default:
          af_state <= vgaac_pkg::VGAAC_AF_INDEX;
      endcase
    end
  end

  // ----------------------------------------
  // indexed attribute registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      attribute_mode    <= `VGAAC_RST_REG;
      border_color      <= `VGAAC_RST_REG;
      plane_enable      <= `VGAAC_RST_REG;
      smooth_pan        <= `VGAAC_RST_REG;
      palette_high_bits <= `VGAAC_RST_REG;
    end
    else if (CORE_CE && attr_data_wr)
    begin
      case (attribute_index_data[4:0])
        `VGAAC_IDX_MODE:   attribute_mode    <= IO_WDATA & `VGAAC_MODE_WMASK;
        `VGAAC_IDX_BORDER: border_color      <= IO_WDATA;
        `VGAAC_IDX_PLANE:  plane_enable      <= IO_WDATA & `VGAAC_LOW4_WMASK;
        `VGAAC_IDX_PAN:    smooth_pan        <= IO_WDATA & `VGAAC_LOW4_WMASK;
        `VGAAC_IDX_CSEL:   palette_high_bits <= IO_WDATA & `VGAAC_LOW4_WMASK;
        default:           border_color      <= border_color;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_pal
      always_ff @(posedge CORE_CLK)
      begin
        if (!RESET_N)
          attribute_palette_entry[i] <= 6'h00;
        else if (CORE_CE && attr_data_wr && attribute_index_data[4:0] == 5'(i))
          attribute_palette_entry[i] <= IO_WDATA[5:0];
      end
    end
  endgenerate

  // mode levels are the register bits themselves
  assign DOUBLE_WIDE           = attribute_mode[`VGAAC_MODE_WIDE];
  assign BLINK_ENABLE          = attribute_mode[`VGAAC_MODE_BLINK];
  assign NINTH_DOT_COPY        = attribute_mode[`VGAAC_MODE_NINTH];
  assign MONO_EMULATION        = attribute_mode[`VGAAC_MODE_MONO];
  assign GRAPHICS_MODE         = attribute_mode[`VGAAC_MODE_GFX];
  assign PAL_ADDR_FROM_DISPLAY = attribute_index_data[`VGAAC_INDEX_PAS];

  // ----------------------------------------
  // pixel mask register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      vga_pixel_mask <= `VGAAC_RST_MASK;
    else if (CORE_CE && IO_WR && IO_ADDR == `VGAAC_IO_MASK)
      vga_pixel_mask <= IO_WDATA;
  end

  // ----------------------------------------
  // host read path
  // ----------------------------------------
  always_comb
  begin
    if (attribute_index_data[4:0] <= `VGAAC_IDX_PAL_LAST)
      attr_rdata = {2'b00, attribute_palette_entry[attribute_index_data[3:0]]};
    else
    begin
      case (attribute_index_data[4:0])
        `VGAAC_IDX_MODE:   attr_rdata = attribute_mode;
        `VGAAC_IDX_BORDER: attr_rdata = border_color;
        `VGAAC_IDX_PLANE:  attr_rdata = plane_enable;
        `VGAAC_IDX_PAN:    attr_rdata = smooth_pan;
        `VGAAC_IDX_CSEL:   attr_rdata = palette_high_bits;
        default:           attr_rdata = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    case (IO_ADDR)
      `VGAAC_IO_ATTR_WR:  next_rdata = attribute_index_data;
      `VGAAC_IO_ATTR_RD:  next_rdata = attr_rdata;
      `VGAAC_IO_MASK:     next_rdata = vga_pixel_mask;
      `VGAAC_IO_RD_INDEX: next_rdata = dac_state_view;
      `VGAAC_IO_WR_INDEX: next_rdata = dac_wr_index;
      `VGAAC_IO_DATA:     next_rdata = dac_data;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      IO_RDATA  <= 8'h00;
      IO_RVALID <= 1'b0;
    end
    else if (CORE_CE)
    begin
      IO_RVALID <= IO_RD;
      if (IO_RD)
        IO_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // smooth panning decode
  // ----------------------------------------
  // reserved codes shift zero rather than anything undefined
  assign pan_code = smooth_pan[3:0];

  always_comb
  begin
    next_pan = 4'h0;
    if (attribute_mode[`VGAAC_MODE_PAN] && LINE_COMPARE)
      next_pan = 4'h0;
    else if (!attribute_mode[`VGAAC_MODE_GFX])
    begin
      if (pan_code <= `VGAAC_PAN_MAX)
        next_pan = pan_code + 4'h1;
    end
    else if (attribute_mode[`VGAAC_MODE_WIDE])
    begin
      if (!pan_code[0] && pan_code <= `VGAAC_PAN_256_MAX)
        next_pan = {1'b0, pan_code[3:1]};
    end
    else if (pan_code <= `VGAAC_PAN_MAX)
      next_pan = pan_code;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      PAN_SHIFT <= 4'h0;
    else if (CORE_CE)
      PAN_SHIFT <= next_pan;
  end

  // ----------------------------------------
  // attribute pixel path
  // ----------------------------------------
  assign attr_idx = PIX_PLANES & plane_enable[3:0];
  assign entry    = attribute_palette_entry[attr_idx];
  assign pix_load = DOT_EN && (!attribute_mode[`VGAAC_MODE_WIDE] || !dot_phase);

  always_comb
  begin
    next_color = {palette_high_bits[3:2], entry};
    if (attribute_mode[`VGAAC_MODE_PSEL])
      next_color[5:4] = palette_high_bits[1:0];
    else
      next_color[5:4] = entry[5:4];
    if (attribute_mode[`VGAAC_MODE_WIDE])
      next_color = PIX_DATA256;
    if (PIX_NINTH && attribute_mode[`VGAAC_MODE_NINTH] && !attribute_mode[`VGAAC_MODE_GFX])
      next_color = held_color;
    if (PIX_BORDER)
      next_color = border_color;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      dot_phase       <= 1'b0;
      held_color      <= 8'h00;
      PIX_INDEX       <= 8'h00;
      PIX_INDEX_VALID <= 1'b0;
    end
    else if (CORE_CE)
    begin
      PIX_INDEX_VALID <= DOT_EN;
      if (DOT_EN)
        dot_phase <= attribute_mode[`VGAAC_MODE_WIDE] ? ~dot_phase : 1'b0;
      if (pix_load)
      begin
        held_color <= next_color;
        PIX_INDEX  <= next_color & vga_pixel_mask;
      end
    end
  end

  // ----------------------------------------
  // palette and DAC colour port
  // ----------------------------------------
  vgaac_palette_port u_palette (
    .clk        (CORE_CLK),
    .rst_n      (RESET_N),
    .ce         (CORE_CE),
    .io         (io_req),
    .host_data  (dac_data),
    .wr_index   (dac_wr_index),
    .state_view (dac_state_view),
    .vid_valid  (PIX_INDEX_VALID),
    .vid_index  (PIX_INDEX),
    .rgb        (PIX_RGB),
    .rgb_valid  (PIX_RGB_VALID)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pan_split_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && attribute_mode[`VGAAC_MODE_PAN] && LINE_COMPARE) |=> PAN_SHIFT == 4'h0)
    else $error("pan not forced to zero on line compare");

  a_pan_text_map: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && !LINE_COMPARE && !attribute_mode[`VGAAC_MODE_GFX] && pan_code == 4'h3)
    |=> PAN_SHIFT == 4'h4)
    else $error("text pan code 3 did not shift 4");

  a_pan_256_map: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && !LINE_COMPARE && attribute_mode[`VGAAC_MODE_GFX]
     && attribute_mode[`VGAAC_MODE_WIDE] && pan_code == 4'h6) |=> PAN_SHIFT == 4'h3)
    else $error("256-colour pan code 6 did not shift 3");

  a_pan_other_map: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && !LINE_COMPARE && attribute_mode[`VGAAC_MODE_GFX]
     && !attribute_mode[`VGAAC_MODE_WIDE] && pan_code == 4'h5) |=> PAN_SHIFT == 4'h5)
    else $error("graphics pan code 5 did not shift 5");

  a_double_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && attribute_mode[`VGAAC_MODE_WIDE] && DOT_EN && dot_phase) |=> $stable(PIX_INDEX))
    else $error("wide pixel changed on its second dot");

  a_border_out: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && pix_load && PIX_BORDER)
    |=> PIX_INDEX == ($past(border_color) & $past(vga_pixel_mask)))
    else $error("border pixel not border colour");

  a_mask_and: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && pix_load) |=> (PIX_INDEX & ~$past(vga_pixel_mask)) == 8'h00)
    else $error("masked pixel bit leaked through");

  a_top_bits: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && pix_load && !PIX_BORDER && !PIX_NINTH && !attribute_mode[`VGAAC_MODE_WIDE]
     && vga_pixel_mask[7:6] == 2'b11) |=> PIX_INDEX[7:6] == $past(palette_high_bits[3:2]))
    else $error("pixel bits 7:6 not from colour select");

  a_attr_toggle: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CORE_CE && IO_WR && IO_ADDR == `VGAAC_IO_ATTR_WR && af_state == vgaac_pkg::VGAAC_AF_INDEX)
    |=> af_state == vgaac_pkg::VGAAC_AF_DATA ##0 attribute_index_data == ($past(IO_WDATA) & 8'h3F))
    else $error("attribute index write did not arm data phase");

endmodule : vgaac_regs

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        io_wr    = 1'b0;
  logic        io_rd    = 1'b0;
  logic [9:0]  io_addr  = 10'h000;
  logic [7:0]  io_wdata = 8'h00;
  logic        dot_en   = 1'b0;
  logic [3:0]  planes   = 4'h0;
  logic [7:0]  data256  = 8'h00;
  logic        border   = 1'b0;
  logic        line_cmp = 1'b0;
  logic        ce       = 1'b1;
  logic        ninth    = 1'b0;
  logic [7:0]  rdata, pix_index, v, mode, msk, csel, pen, idx;
  logic        rvalid, dwide, blink, ninth_copy, mono, gfx, pal_disp, ixv, rgbv;
  logic [3:0]  split_scroll_reset;
  logic [23:0] pix_rgb, col, rgb;
  logic [5:0]  e;
  logic [5:0]  ent [16];
  logic [31:0] seed = 32'h5FA75663;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #4 core_clk = ~core_clk;

  // every input driven, so freeze and ninth-dot copy get exercised
  vgaac_regs dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .CORE_CE(ce), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_RDATA(rdata),
    .IO_RVALID(rvalid), .DOT_EN(dot_en), .PIX_PLANES(planes), .PIX_DATA256(data256),
    .PIX_BORDER(border), .PIX_NINTH(ninth), .LINE_COMPARE(line_cmp), .PAN_SHIFT(split_scroll_reset),
    .DOUBLE_WIDE(dwide), .BLINK_ENABLE(blink), .NINTH_DOT_COPY(ninth_copy),
    .MONO_EMULATION(mono), .GRAPHICS_MODE(gfx), .PAL_ADDR_FROM_DISPLAY(pal_disp),
    .PIX_INDEX(pix_index), .PIX_INDEX_VALID(ixv), .PIX_RGB(pix_rgb), .PIX_RGB_VALID(rgbv));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd8

  task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task io_w(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask : io_w

  task io_r(input logic [9:0] a, output logic [7:0] d);
    @(negedge core_clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge core_clk);
    io_rd = 1'b0;
    chk("read valid", rvalid, 24'h1);
    d = rdata;
  endtask : io_r

  // bit 5 of the index kept set so the display owns the palette address
  task aw(input logic [4:0] i, input logic [7:0] d);
    io_w(10'h3C0, {3'b001, i});
    io_w(10'h3C0, d);
  endtask : aw

  // a 3C1 read leaves the flip-flop on data, so the value goes back to close it
  task ar(input logic [4:0] i, output logic [7:0] d);
    io_w(10'h3C0, {3'b001, i});
    io_r(10'h3C1, d);
    io_w(10'h3C0, d);
  endtask : ar

  task dot(input logic [3:0] p, input logic b);
    @(negedge core_clk);
    planes = p;
    border = b;
    dot_en = 1'b1;
    @(negedge core_clk);
    dot_en = 1'b0;
    chk("index valid", ixv, 24'h1);
    idx = pix_index;
    @(negedge core_clk);
    chk("rgb valid", rgbv, 24'h1);
    rgb = pix_rgb;
  endtask : dot

  function automatic logic [3:0] pan_exp(input logic [7:0] m, input logic [3:0] c);
    if (m[5] && line_cmp)
      return 4'h0;
    if (!m[0])
      return (c <= 4'h7) ? c + 4'h1 : 4'h0;
    if (m[6])
      return (!c[0] && c <= 4'h6) ? c >> 1 : 4'h0;
    return (c <= 4'h7) ? c : 4'h0;
  endfunction : pan_exp

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      mode = rnd8();
      aw(5'h10, mode & 8'hEF);
      ar(5'h10, v);
      chk("mode", v, mode & 8'hEF);
      chk("wide out", dwide, mode[6]);
      chk("mode outs", {blink, ninth_copy, mono, gfx}, mode[3:0]);
    end
    chk("palette source", pal_disp, 24'h1);
    $display("test mode done");
    for (int k = 0; k < 8; k++)
    begin
      mode = {1'b0, k[1], k[2], 4'h0, k[0]};
      line_cmp = k[0] ^ k[1];
      aw(5'h10, mode);
      for (int c = 0; c < 16; c++)
      begin
        aw(5'h13, {4'h0, c[3:0]});
        repeat (2) @(negedge core_clk);
        chk("pan", split_scroll_reset, pan_exp(mode, c[3:0]));
      end
    end
    line_cmp = 1'b0;
    $display("test pan done");
    aw(5'h10, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      v = rnd8();
      col = seed[23:0];
      io_w(10'h3C8, v);
      io_r(10'h3C7, idx);
      chk("state write", idx, 24'h00);
      for (int c = 2; c >= 0; c--)
      begin
        io_r(10'h3C7, idx);
        chk("state seq", idx, 24'(2 - c));
        io_w(10'h3C9, col[8*c +: 8]);
      end
      io_r(10'h3C8, idx);
      chk("write index", idx, v + 8'h01);
      io_w(10'h3C7, v);
      io_r(10'h3C7, idx);
      chk("state read", idx, 24'h04);
      for (int c = 2; c >= 0; c--)
      begin
        io_r(10'h3C9, idx);
        chk("colour read", idx, col[8*c +: 8]);
      end
      aw(5'h11, v);
      dot(4'h0, 1'b1);
      chk("border index", idx, v);
      chk("border rgb", rgb, col);
      msk = rnd8();
      io_w(10'h3C6, msk);
      io_r(10'h3C6, idx);
      chk("mask", idx, msk);
      dot(4'h0, 1'b1);
      chk("masked index", idx, v & msk);
      io_w(10'h3C6, 8'hFF);
    end
    // a write while the clock enable is low must be lost
    ce = 1'b0;
    io_w(10'h3C6, 8'h00);
    ce = 1'b1;
    io_r(10'h3C6, v);
    chk("frozen mask", v, 24'hFF);
    $display("test dac done");
    for (int i = 0; i < 16; i++)
    begin
      v = rnd8();
      ent[i] = v[5:0];
      aw(i[4:0], {2'b00, v[5:0]});
    end
    for (int k = 0; k < 16; k++)
    begin
      csel = rnd8();
      pen = rnd8();
      aw(5'h10, {csel[7], 7'h00});
      aw(5'h14, {4'h0, csel[3:0]});
      aw(5'h12, {4'h0, pen[3:0]});
      ar(5'h12, v);
      chk("plane enable", v, {4'h0, pen[3:0]});
      v = rnd8();
      dot(v[3:0], 1'b0);
      e = ent[v[3:0] & pen[3:0]];
      msk = {csel[3:2], (csel[7] ? csel[1:0] : e[5:4]), e[3:0]};
      chk("attr index", idx, msk);
    end
    aw(5'h12, 8'h0F);
    aw(5'h10, 8'h04);
    dot(4'h0, 1'b0);
    chk("ninth base", idx, {csel[3:2], ent[0]});
    ninth = 1'b1;
    dot(4'hF, 1'b0);
    ninth = 1'b0;
    chk("ninth copy", idx, {csel[3:2], ent[0]});
    aw(5'h10, 8'h41);
    data256 = rnd8();
    dot(4'h0, 1'b0);
    chk("256 index", idx, data256);
    pen = data256;
    data256 = ~pen;
    dot(4'h0, 1'b0);
    chk("wide hold", idx, pen);
    dot(4'h0, 1'b0);
    chk("wide next", idx, data256);
    io_r(10'h3C2, v);
    chk("unmapped", v, 24'h00);
    $display("test attribute done");
    test_done();
  end
endmodule : tb
